/* pkg/sar_adc_defines.svh */
// named constants for the converter readout logic
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH

// word layout
`define SAR_WORD_W        16
`define SAR_CNT_W         10
// clock period of the block, ns
`define SAR_CLK_NS        5
// longest conversion (busy low), ns, rounded down to cycles
`define SAR_CONV_MAX_NS   2200
`define SAR_CONV_CYC      (`SAR_CONV_MAX_NS / `SAR_CLK_NS)
// start to first internal shift clock, ns, rounded up
`define SAR_INT_DLY_NS    270
`define SAR_INT_DLY_CYC   ((`SAR_INT_DLY_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
// internal shift clock period, ns; half period rounded up
`define SAR_INT_PER_NS    110
`define SAR_INT_HALF_CYC  (((`SAR_INT_PER_NS / 2) + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
// internal clock rises this far into each bit slot
`define SAR_INT_LEAD_CYC  (`SAR_INT_HALF_CYC / 2)
// external read sequencer rise counts
`define SAR_EXT_CNT_W     2
`define SAR_EXT_CNT_ZERO  2'h0
`define SAR_EXT_CNT_ONE   2'h1
`define SAR_EXT_CNT_SAT   2'h2
// reset levels
`define SAR_RST_BUSY      1'b1
`define SAR_RST_PINS      6'h00

`endif

/* pkg/sar_adc_pkg.sv */
// types and helpers shared by the converter readout logic
`include "sar_adc_defines.svh"
package sar_adc_pkg;

  // conversion sequencer, gray along idle-run-store
  typedef enum logic [1:0]
  {
    CONV_IDLE  = 2'b00,
    CONV_RUN   = 2'b01,
    CONV_STORE = 2'b11
  } conv_state_t;

  // internal shift clock generator, gray along idle-wait-shift
  typedef enum logic [1:0]
  {
    ICL_IDLE  = 2'b00,
    ICL_WAIT  = 2'b01,
    ICL_SHIFT = 2'b11
  } icl_state_t;

  typedef logic [`SAR_WORD_W-1:0] word_t;

  // straight binary when sel high, else flip msb for two's complement
  function automatic word_t fmt_word(input word_t code, input logic sel);
    word_t w;
    w = code;
    w[`SAR_WORD_W-1] = sel ? code[`SAR_WORD_W-1] : ~code[`SAR_WORD_W-1];
    return w;
  endfunction : fmt_word

  // rising edge of a sampled level
  function automatic logic rose(input logic now, input logic prev);
    return now & ~prev;
  endfunction : rose

endpackage : sar_adc_pkg

/* rtl/sync_2ff.sv */
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;   // first stage, read only by q

  generate
    if (W < 1)
    begin : g_chk
      $error("sync_2ff: W must be at least 1");
    end
  endgenerate

  // both stages clear to zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : sync_2ff
`default_nettype wire

/* rtl/word_buffer2.sv */
// small ring buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_buffer2 #(
  parameter int W     = 17,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem [DEPTH];  // storage, no reset needed
  logic [PW-1:0] wr_r;         // write pointer
  logic [PW-1:0] rd_r;         // read pointer
  logic [PW:0]   cnt_r;        // words held
  logic          push;
  logic          pop;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_chk
      $error("word_buffer2: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  // honest full and empty from the count
  assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rd_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // data store
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_r] <= in_data;
  end

  // pointers and count
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wr_r <= wr_r + PW'(1);
      if (pop)
        rd_r <= rd_r + PW'(1);
      // simultaneous push and pop keep the count
      if (push && !pop)
        cnt_r <= cnt_r + (PW+1)'(1);
      else if (pop && !push)
        cnt_r <= cnt_r - (PW+1)'(1);
    end
  end

endmodule : word_buffer2
`default_nettype wire

/* rtl/sar_adc_serial_readout.sv */
// conversion start, busy and serial result readout of the converter
// What this block does, and what the host must do
// [R1] both selects low starts conversion, last edge
// [R2] busy low during conversion, high once stored
// [R3] reads always return latest completed result
// [R4] msb first, coding chosen by format input
// [R5] format high straight binary, low two's complement
// [R6] first result after power-up flagged invalid
// [R7] clock select low drives shift clock out
// [R8] internal mode sends sixteen pulses per conversion
// [R9] internal clock idles low, data spans rise-fall
// [R10] after word, data shows chain input from start
// [R11] external mode: selects define the read state
// [R12] external data changes on rise, spans fall-rise
// [R13] host keeps external clock under 28.5 MHz
// [R14] host runs external clock only while reading
// [R15] host stops clock in conversion second half
// [R16] host's last edge within 1 us of busy fall
// [R17] acquisition read ends before next conversion
// [R18] free-running edge outside read arms frame marker
// [R19] host gives 17 or 18 clocks with marker
// [R20] idle clock outside read gives no marker
// [R21] without marker first rise presents msb
// [R22] chain input passes through after word, separator
// [R23] chaining uses external clock only
// [R24] chain reads all words during acquisition
// [R25] busy low no longer than 2.2 us
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_defines.svh"
module sar_adc_serial_readout #(
  parameter int CONV_CYC = `SAR_CONV_CYC,
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input  wire logic                   CLK,
  input  wire logic                   NRST,
  // conversion control pins, active low
  input  wire logic                   CS_N,
  input  wire logic                   RC_N,
  // mode straps
  input  wire logic                   CLK_SRC_SEL,
  input  wire logic                   OUTPUT_FORMAT_SELECT,
  // result from the analog core, straight binary, same clock
  input  wire logic [`SAR_WORD_W-1:0] CORE_CODE,
  // serial link
  input  wire logic                   SERIAL_SHIFT_CLOCK_I,
  output logic                        SERIAL_SHIFT_CLOCK_O,
  output logic                        SERIAL_SHIFT_CLOCK_OE,
  output logic                        SDATA_O,
  output logic                        SYNC_O,
  input  wire logic                   TAG_I,
  // status
  output logic                        BUSY,
  output logic                        RESULT_VALID
);
  import sar_adc_pkg::*;

  // every check below samples on the block clock, off during reset
  default clocking cb_blk @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  localparam int CW = `SAR_CNT_W;
  localparam int WW = `SAR_WORD_W;
  localparam int HALF = `SAR_INT_HALF_CYC;
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYC - 2);
  localparam logic [CW-1:0] DLY_LAST  = CW'(`SAR_INT_DLY_CYC - 1);
  localparam logic [CW-1:0] PH_LAST   = CW'(2 * HALF - 1);
  localparam logic [CW-1:0] PH_RISE   = CW'(`SAR_INT_LEAD_CYC);
  localparam logic [CW-1:0] PH_FALL   = CW'(`SAR_INT_LEAD_CYC + HALF);
  localparam logic [4:0]    BIT_LAST  = 5'(WW - 1);

  generate
    if (CONV_CYC < 2 || CONV_CYC >= (1 << CW) || HALF < 2)
    begin : g_chk
      $error("sar_adc_serial_readout: CONV_CYC or clock timing out of range");
    end
  endgenerate

  // synchronised pins
  logic [5:0] pins_s;
  logic       cs_n_s, rc_n_s, ext_sel_s, fmt_s, sclk_s, tag_s;

  sync_2ff #(.W(6)) u_sync (
    .clk  (CLK),
    .nrst (NRST),
    .d    ({CS_N, RC_N, CLK_SRC_SEL, OUTPUT_FORMAT_SELECT,
            SERIAL_SHIFT_CLOCK_I, TAG_I}),
    .q    (pins_s)
  );
  assign {cs_n_s, rc_n_s, ext_sel_s, fmt_s, sclk_s, tag_s} = pins_s;

  logic low_d_r;     // both selects were low last cycle
  logic sclk_d_r;    // last sampled external clock
  logic start_req;   // conversion start pulse
  logic ext_rise;    // rising edge of the host clock
  logic both_low;    // both selects low now
  logic in_read;     // external read state

  assign both_low = ~cs_n_s & ~rc_n_s;
  assign start_req = rose(both_low, low_d_r); // see [R1]
  assign ext_rise = rose(sclk_s, sclk_d_r);
  assign in_read = ext_sel_s & ~cs_n_s & rc_n_s; // see [R11]

  // edge history; reset as if already low so no start at release
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      low_d_r  <= 1'b1;
      sclk_d_r <= 1'b0;
    end
    else
    begin
      low_d_r  <= both_low;
      sclk_d_r <= sclk_s;
    end
  end

  // conversion sequencer and busy
  conv_state_t   conv_state_r;
  logic [CW-1:0] conv_cnt_r;    // cycles into the conversion
  logic          done_once_r;   // a first result has been stored
  logic          push_ready;    // buffer can take a word
  logic          push_valid;

  assign push_valid = (conv_state_r == CONV_STORE);

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      conv_state_r <= CONV_IDLE;
      conv_cnt_r   <= '0;
      BUSY         <= `SAR_RST_BUSY;
      done_once_r  <= 1'b0;
    end
    else
    begin
      unique case (conv_state_r)
        CONV_IDLE:
        begin
          // a start while converting is ignored
          if (start_req)
          begin
            conv_state_r <= CONV_RUN;
            conv_cnt_r   <= '0;
            BUSY         <= 1'b0; // see [R2]
          end
        end
        CONV_RUN:
        begin
          conv_cnt_r <= conv_cnt_r + CW'(1);
          if (conv_cnt_r == CONV_LAST)
            conv_state_r <= CONV_STORE; // see [R25]
        end
        CONV_STORE:
        begin
          // busy rises only once the word is held; acquisition follows
          if (push_ready)
          begin
            conv_state_r <= CONV_IDLE;
            BUSY         <= 1'b1; // see [R2]
            done_once_r  <= 1'b1; // see [R6]
          end
        end
        // the unused code would otherwise lock the sequencer
        default:
        begin
          conv_state_r <= CONV_IDLE;
        end
      endcase
    end
  end

  // result path: buffer decouples the converter from a busy shifter
  logic [WW:0] pop_data;   // {valid, code}
  logic        pop_valid;
  logic        pop_ready;
  logic        xfer_act;   // a serial transfer owns the shifter
  logic [WW:0] store_r;    // latest completed result

  word_buffer2 #(.W(WW + 1), .DEPTH(BUF_DEPTH)) u_buf (
    .clk       (CLK),
    .nrst      (NRST),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   ({done_once_r, CORE_CODE}), // see [R6]
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_data)
  );

  // storage only moves between transfers so a read never tears
  assign pop_ready = ~xfer_act;

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      store_r <= '0;
    else if (pop_valid && pop_ready)
      store_r <= pop_data; // see [R3]
  end

  // internal shift clock generator
  icl_state_t    icl_state_r;
  logic [CW-1:0] icl_cnt_r;   // delay, then phase within a bit
  logic [4:0]    icl_bit_r;   // bit slot index
  logic          icl_load;
  logic          icl_shift;

  assign icl_load  = (icl_state_r == ICL_WAIT) && (icl_cnt_r == DLY_LAST);
  assign icl_shift = (icl_state_r == ICL_SHIFT) && (icl_cnt_r == PH_LAST);

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      icl_state_r <= ICL_IDLE;
      icl_cnt_r   <= '0;
      icl_bit_r   <= '0;
    end
    else
    begin
      unique case (icl_state_r)
        ICL_IDLE:
        begin
          // in internal clock mode runs every conversion whatever the selects do after
          if (start_req && !ext_sel_s && (conv_state_r == CONV_IDLE))
          begin
            icl_state_r <= ICL_WAIT; // see [R8]
            icl_cnt_r   <= '0;
          end
        end
        ICL_WAIT:
        begin
          icl_cnt_r <= icl_cnt_r + CW'(1);
          if (icl_load)
          begin
            icl_state_r <= ICL_SHIFT;
            icl_cnt_r   <= '0;
            icl_bit_r   <= '0;
          end
        end
        ICL_SHIFT:
        begin
          icl_cnt_r <= icl_cnt_r + CW'(1);
          if (icl_shift)
          begin
            icl_cnt_r <= '0;
            icl_bit_r <= icl_bit_r + 5'(1);
            if (icl_bit_r == BIT_LAST)
              icl_state_r <= ICL_IDLE; // see [R8]
          end
        end
        default:
        begin
          icl_state_r <= ICL_IDLE;
        end
      endcase
    end
  end

  // clock high mid-slot so data changes only while it is low
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      SERIAL_SHIFT_CLOCK_O <= 1'b0;
    else
      SERIAL_SHIFT_CLOCK_O <= (icl_state_r == ICL_SHIFT) &&
                              (icl_cnt_r >= PH_RISE) &&
                              (icl_cnt_r < PH_FALL); // see [R9]
  end

  // pin drives only in internal clock mode
  assign SERIAL_SHIFT_CLOCK_OE = ~ext_sel_s; // see [R7]

  // external read sequencer and frame marker
  logic                     ext_act_r;   // inside a read state
  logic [`SAR_EXT_CNT_W-1:0] ext_cnt_r;  // host rises seen, saturating
  logic                     sync_mode_r; // this read uses the marker
  logic                     seen_free_r; // rise seen outside read
  logic                     ext_load;
  logic                     ext_show;
  logic                     ext_shift;
  logic                     ext_first;

  assign ext_load  = in_read & ~ext_act_r;
  assign ext_first = sync_mode_r ? (ext_cnt_r == `SAR_EXT_CNT_ONE)
                                 : (ext_cnt_r == `SAR_EXT_CNT_ZERO);
  assign ext_show  = ext_act_r & in_read & ext_rise & ext_first; // see [R21]
  assign ext_shift = ext_act_r & in_read & ext_rise & ~ext_first &
                     (ext_cnt_r != `SAR_EXT_CNT_ZERO); // see [R12]

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ext_act_r   <= 1'b0;
      ext_cnt_r   <= `SAR_EXT_CNT_ZERO;
      sync_mode_r <= 1'b0;
      seen_free_r <= 1'b0;
      SYNC_O      <= 1'b0;
    end
    else if (!in_read)
    begin
      ext_act_r <= 1'b0;
      SYNC_O    <= 1'b0;
      // any free edge outside read in external clock mode arms the marker
      if (ext_sel_s && ext_rise)
        seen_free_r <= 1'b1; // see [R18]
    end
    else if (!ext_act_r)
    begin
      ext_act_r   <= 1'b1;
      ext_cnt_r   <= `SAR_EXT_CNT_ZERO;
      sync_mode_r <= seen_free_r; // see [R20]
      seen_free_r <= 1'b0;
    end
    else if (ext_rise)
    begin
      if (ext_cnt_r != `SAR_EXT_CNT_SAT)
        ext_cnt_r <= ext_cnt_r + `SAR_EXT_CNT_ONE;
      // marker stands from first rise to the next
      SYNC_O <= sync_mode_r && (ext_cnt_r == `SAR_EXT_CNT_ZERO); // see [R18]
    end
  end

  // shifter shared by both clock modes
  logic [WW:0] sh_r;        // word then separator, tail fills from chain
  logic        show_r;      // word on the data pin, else held chain level
  logic        tag_l_r;     // chain level caught at transfer start
  logic        load;
  logic        shift;
  word_t       fmt_code;

  assign load     = icl_load | ext_load;
  assign shift    = icl_shift | ext_shift;
  assign fmt_code = fmt_word(store_r[WW-1:0], fmt_s); // see [R5]
  assign xfer_act = (icl_state_r != ICL_IDLE) | ext_act_r;

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sh_r         <= '0;
      show_r       <= 1'b0;
      tag_l_r      <= 1'b0;
      RESULT_VALID <= 1'b0;
    end
    else if (load)
    begin
      sh_r         <= {fmt_code, tag_s}; // see [R4]
      tag_l_r      <= tag_s; // see [R10]
      show_r       <= icl_load;
      RESULT_VALID <= store_r[WW]; // see [R6]
    end
    else if (ext_show)
      show_r <= 1'b1; // see [R21]
    else if (shift)
      sh_r <= {sh_r[WW-1:0], tag_s}; // see [R22]
    else if (ext_act_r && !in_read)
      show_r <= 1'b0;
  end

  // data pin from a flop
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      SDATA_O <= 1'b0;
    else
      SDATA_O <= show_r ? sh_r[WW] : tag_l_r; // see [R10]
  end

  // helper counts for the checks below
  logic [CW-1:0] busy_lo_r;   // cycles busy has been low
  logic [4:0]    icl_rises_r; // internal clock pulses this transfer

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      busy_lo_r   <= '0;
      icl_rises_r <= '0;
    end
    else
    begin
      busy_lo_r <= BUSY ? '0 : busy_lo_r + CW'(1);
      if (icl_load)
        icl_rises_r <= '0;
      else if ((icl_state_r == ICL_SHIFT) && (icl_cnt_r == PH_RISE))
        icl_rises_r <= icl_rises_r + 5'(1);
    end
  end

  sequence s_start_idle;
    start_req && (conv_state_r == CONV_IDLE);
  endsequence

  sequence s_word_taken;
    push_valid && push_ready;
  endsequence

  a_start_busy_low: assert property ( // see [R1]
    s_start_idle |=> !BUSY [*2])
    else $error("busy did not fall after conversion start");
  a_busy_rise_store: assert property ( // see [R2]
    $rose(BUSY) |-> $past(push_valid) && $past(push_ready))
    else $error("busy rose without the result being stored");
  a_busy_low_max: assert property ( // see [R25]
    (conv_state_r == CONV_RUN) |-> (busy_lo_r < CW'(CONV_CYC)))
    else $error("conversion held busy too long");
  a_store_latest: assert property ( // see [R3]
    (pop_valid && pop_ready) |=> (store_r == $past(pop_data)))
    else $error("storage did not take the completed result");
  a_first_invalid: assert property ( // see [R6]
    s_word_taken ##0 !done_once_r |=> BUSY && done_once_r)
    else $error("first result not marked");
  a_msb_first_fmt: assert property ( // see [R4]
    load |=> (sh_r[WW:1] == $past(fmt_code)))
    else $error("loaded word not msb first in chosen coding");
  a_int_sixteen: assert property ( // see [R8]
    (icl_shift && icl_bit_r == BIT_LAST) |-> (icl_rises_r == 5'(WW)))
    else $error("internal transfer did not give sixteen pulses");
  a_int_idle_low: assert property ( // see [R9]
    (icl_state_r != ICL_SHIFT) ##1 (icl_state_r != ICL_SHIFT)
      |-> !SERIAL_SHIFT_CLOCK_O)
    else $error("internal shift clock not low while idle");
  a_tail_is_tag: assert property ( // see [R10]
    (icl_shift && icl_bit_r == BIT_LAST) |=> ##1 (SDATA_O == tag_l_r))
    else $error("data pin not at chain level after word");
  a_sync_marker: assert property ( // see [R18]
    (ext_act_r && in_read && ext_rise && sync_mode_r &&
     ext_cnt_r == `SAR_EXT_CNT_ZERO) |=> SYNC_O)
    else $error("frame marker missing on first rise");
  a_no_marker: assert property ( // see [R20]
    (ext_act_r && !sync_mode_r) |-> !SYNC_O)
    else $error("frame marker without a free clock edge");
  a_ext_shift_rise: assert property ( // see [R12]
    ext_shift |=> (sh_r[WW] == $past(sh_r[WW-1])))
    else $error("external shift did not advance one bit");
  a_read_ends: assert property ( // see [R11]
    !in_read |=> !ext_act_r)
    else $error("read state outlived the selects");

endmodule : sar_adc_serial_readout
`default_nettype wire

/* verification/host_sclk_model.sv */
// host serial port model: shift clock bursts, captures data and marker
`timescale 1ns/1ps
`default_nettype none
module host_sclk_model (
  // serial link, host side
  output var logic sclk,
  input  wire logic sdata,
  input  wire logic sync
);
  logic [17:0] cap; // data seen at each falling edge
  logic [17:0] syn; // marker seen at each falling edge
  // clock stands low between frames and never runs while converting,
  initial sclk = 1'b0;
  // 48 ns period keeps under the host limit
  task burst(input int n);
    cap = '0;
    syn = '0;
    repeat (n)
    begin
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
      cap = {cap[16:0], sdata};
      syn = {syn[16:0], sync};
    end
  endtask : burst
endmodule : host_sclk_model
`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench for the converter readout block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sar_adc_pkg::*;
  logic  clk, nrst, cs_n, rc_n, src_sel, fmt_sel, tag;
  logic  sclk_i, sclk_o, sclk_oe, sdata, sync, busy, rvalid;
  word_t code;    // core result fed in
  word_t icap;    // internal mode bits, caught on clock rise
  logic [17:0] cap, syn; // host captures, copied after each read
  int    ipul;    // internal clock pulses seen
  int    lo;      // cycles busy stayed low
  int    err_total, cmp_count, cyc;
  sar_adc_serial_readout sar_adc_serial_readout_i (
    .CLK(clk), .NRST(nrst), .CS_N(cs_n), .RC_N(rc_n),
    .CLK_SRC_SEL(src_sel), .OUTPUT_FORMAT_SELECT(fmt_sel),
    .CORE_CODE(code), .SERIAL_SHIFT_CLOCK_I(sclk_i),
    .SERIAL_SHIFT_CLOCK_O(sclk_o), .SERIAL_SHIFT_CLOCK_OE(sclk_oe),
    .SDATA_O(sdata), .SYNC_O(sync), .TAG_I(tag),
    .BUSY(busy), .RESULT_VALID(rvalid));
  host_sclk_model host_sclk_model_i (
    .sclk(sclk_i), .sdata(sdata), .sync(sync));
  // 200 MHz block clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // internal readout monitor, bits valid at the rise
  always @(posedge sclk_o)
  begin
    icap = {icap[14:0], sdata};
    ipul = ipul + 1;
  end
  // hang guard, tests need well under this
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e)
    begin
      err_total = err_total + 1;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one conversion; selects start high, either falls last
  task conv(input word_t c, input logic cs_last);
    code = c;
    ipul = 0;
    if (cs_last)
    begin
      rc_n = 1'b0;
      repeat (10) @(negedge clk);
      chk("busy_cs_high", 1, busy);
      cs_n = 1'b0;
    end
    else
    begin
      cs_n = 1'b0;
      repeat (3) @(negedge clk);
      rc_n = 1'b0;
    end
    for (lo = 0; lo < 10 && busy !== 1'b0; lo++) @(negedge clk);
    chk("busy_fall", 0, busy);
    cs_n = 1'b1;
    rc_n = 1'b1;
    for (lo = 0; lo < 1000 && busy !== 1'b1; lo++) @(negedge clk);
  endtask : conv
  // host read of n clocks; keeps a copy of what the host caught
  task host_read(input int n);
    host_sclk_model_i.burst(n);
    cap = host_sclk_model_i.cap;
    syn = host_sclk_model_i.syn;
  endtask : host_read
  task t_reset;
    chk("busy_rst", 1, busy);
    chk("oe_int", 1, sclk_oe);
    chk("sclk_idle", 0, sclk_o);
  endtask : t_reset
  // internal clock readout carries the previous result
  task t_internal;
    conv(16'h1234, 1'b0);
    conv(16'hA5C3, 1'b1);
    chk("busy_back", 1, busy);
    chk("busy_len", 1, lo <= 440);
    chk("pulses", 16, ipul);
    chk("int_word", 16'h9234, icap);
    chk("int_tail", tag, sdata);
    chk("first_bad", 0, rvalid);
  endtask : t_internal
  // external clock, no free edges outside read: no marker; the chain
  // input flips after entry, so the null bit keeps the entry level
  // and the bit after it is the chained one
  task t_ext_plain;
    src_sel = 1'b1;
    fmt_sel = 1'b1;
    tag = 1'b0;
    repeat (4) @(negedge clk);
    chk("oe_ext", 0, sclk_oe);
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
    tag = 1'b1;
    host_read(18);
    chk("ext_word", {16'hA5C3, 1'b0, 1'b1}, cap);
    chk("ext_chain", 2'b01, cap[1:0]);
    chk("no_mark", 0, syn);
    chk("valid", 1, rvalid);
    @(negedge clk);
    cs_n = 1'b1;
  endtask : t_ext_plain
  // one edge outside read arms the marker; before the data the pin
  // shows the chain level caught at entry
  task t_ext_sync;
    tag = 1'b1;
    repeat (4) @(negedge clk);
    host_read(1);
    @(negedge clk);
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
    host_read(18);
    chk("mark", 18'h20000, syn);
    chk("mark_word", {1'b1, 16'hA5C3, 1'b1}, cap);
    @(negedge clk);
    cs_n = 1'b1;
  endtask : t_ext_sync
  initial
  begin
    nrst = 1'b0;
    cs_n = 1'b1;
    rc_n = 1'b1;
    src_sel = 1'b0;
    fmt_sel = 1'b0;
    tag = 1'b1;
    code = '0;
    icap = '0;
    ipul = 0;
    lo = 0;
    err_total = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_internal();
    t_ext_plain();
    t_ext_sync();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
